/* logic/bie_cfg.svh */
// Constants for the byte and immediate execute block
`ifndef BIE_CFG_SVH
`define BIE_CFG_SVH
// ----------------------------------------
// Instruction fields
// ----------------------------------------
`define BIE_CLS_HI   15
`define BIE_CLS_LO   11
`define BIE_OP_HI    10
`define BIE_OP_LO    8
`define BIE_D_HI     7
`define BIE_IND_BIT  8
// ----------------------------------------
// Class codes in bits 15-11
// ----------------------------------------
`define BIE_CLS_XOR  5'h15
`define BIE_CLS_CMP  5'h1A
`define BIE_CLS_IMM  5'h18
// ----------------------------------------
// Immediate operations in bits 10-8
// ----------------------------------------
`define BIE_IMM_ADD_X 3'h2
`define BIE_IMM_SUB_X 3'h3
`define BIE_IMM_LD_XP 3'h4
`define BIE_IMM_LD_XN 3'h5
`define BIE_IMM_LD_AP 3'h6
`define BIE_IMM_LD_AN 3'h7
// ----------------------------------------
// Byte addressing modes in bits 10-8
// ----------------------------------------
`define BIE_M_SP     3'h0
`define BIE_M_ISP    3'h1
`define BIE_M_PF0    3'h2
`define BIE_M_IPF    3'h3
`define BIE_M_IDX    3'h4
`define BIE_M_ISPX   3'h5
`define BIE_M_PF1    3'h6
`define BIE_M_IPB    3'h7
// ----------------------------------------
// Timing and program counter steps
// ----------------------------------------
`define BIE_CYC_IMM  2'h1
`define BIE_CYC_BYTE 2'h2
`define BIE_CYC_IND  2'h3
`define BIE_STEP_LT  16'h0001
`define BIE_STEP_GT  16'h0002
`define BIE_STEP_EQ  16'h0003
// ----------------------------------------
// Reset values
// ----------------------------------------
`define BIE_WORD_RST 16'h0000
`endif

/* logic/bie_pkg.sv */
// Types shared by the byte and immediate execute block
`default_nettype none
package bie_pkg;
   // Sequencer states
   typedef enum logic [1:0] {
      BIE_ST_IDLE = 2'b00,
      BIE_ST_PTR  = 2'b01,
      BIE_ST_OPND = 2'b10
   } bie_state_e;
   // Programmer-visible processor state
   typedef struct packed {
      logic [15:0] acc;
      logic [15:0] idx;
      logic [15:0] pc;
      logic        overflow_indicator;
   } bie_regs_s;
endpackage : bie_pkg
`default_nettype wire

/* logic/bie_core.sv */
// Decode and execute of byte xor, byte compare-skip and immediates
`include "bie_cfg.svh"
`default_nettype none
// How it works
// - Byte xor changes accumulator low byte only
// - Forward P-relative and backward indirect addressing
// - Indirect indexed: scratchpad pointer plus index
// - Byte ops two cycles, indirect three
// - Compare skips none, one or two
// - Compare is full 16-bit, byte zero-extended
// - No interrupt after a skipping compare
// - Immediate class decoded from bits 11-15
// - Bits 8-10 pick the immediate operation
// - Immediate operand is zero-extended low byte
// - Immediates finish in one cycle
// - Add to index sets overflow
// - Subtract from index sets overflow
// - Load accumulator positive clears upper byte
// - Load index positive clears upper byte
// - Load accumulator negative stores negation
// - Load index negative stores negation
module bie_core (
   input  wire logic                clk_i,
   input  wire logic                rstn_i,
   input  wire logic                ld_i,
   input  wire bie_pkg::bie_regs_s  ld_regs_i,
   input  wire logic                instr_valid_i,
   input  wire logic [15:0]         instr_i,
   input  wire logic                mem_ack_i,
   input  wire logic [15:0]         mem_rdata_i,
   output logic                     ready_o,
   output logic                     mem_rd_o,
   output logic [15:0]              mem_addr_o,
   output bie_pkg::bie_regs_s       regs_o,
   output logic                     done_o,
   output logic [1:0]               cycles_o,
   output logic                     intr_inhibit_o,
   output logic                     unsupported_o
);
   import bie_pkg::*;

   // ----------------------------------------
   // State
   // ----------------------------------------
   bie_state_e  state;
   bie_state_e  next_state;
   bie_regs_s   regs;
   bie_regs_s   next_regs;
   logic [15:0] instr;
   logic [15:0] next_instr;
   logic        bsel;
   logic        next_bsel;
   logic        ready;
   logic        next_ready;
   logic        mem_rd;
   logic        next_mem_rd;
   logic [15:0] mem_addr;
   logic [15:0] next_mem_addr;
   logic        done;
   logic        next_done;
   logic [1:0]  cycles;
   logic [1:0]  next_cycles;
   logic        inhibit;
   logic        next_inhibit;
   logic        unsup;
   logic        next_unsup;

   // ----------------------------------------
   // Decode helpers
   // ----------------------------------------
   logic [4:0]  cls;
   logic [2:0]  op;
   logic [15:0] dval;
   logic [15:0] neg_d;
   logic [15:0] x_sum;
   logic [15:0] x_dif;
   logic        add_ovf;
   logic        sub_ovf;
   logic [2:0]  lmode;
   logic        lxor;
   logic        cmp_lt;
   logic        cmp_gt;
   logic [15:0] ptr_ba;
   logic [7:0]  byte_val;
   logic [15:0] opnd;
   logic        lind;

   // Fields of the incoming instruction
   assign cls   = instr_i[`BIE_CLS_HI:`BIE_CLS_LO];
   assign op    = instr_i[`BIE_OP_HI:`BIE_OP_LO];
   assign dval  = {8'h00, instr_i[`BIE_D_HI:0]};
   // Negation and index sums are shared by the add, subtract and load-negative immediate ops
   assign neg_d = 16'h0000 - dval;
   assign x_sum = regs.idx + dval;
   assign x_dif = regs.idx + neg_d;
   // Operand is positive, so only a positive index can overflow on add
   assign add_ovf = ~regs.idx[15] & x_sum[15];
   // Subtracting a positive value overflows only from a negative index
   assign sub_ovf = regs.idx[15] & ~x_dif[15];

   // Fields of the latched byte instruction
   assign lmode  = instr[`BIE_OP_HI:`BIE_OP_LO];
   assign lind   = instr[`BIE_IND_BIT];
   assign lxor   = (instr[`BIE_CLS_HI:`BIE_CLS_LO] == `BIE_CLS_XOR);
   // Pointer word is a byte address; indexed form adds the index
   assign ptr_ba = (lmode == `BIE_M_ISPX) ? mem_rdata_i + regs.idx
                                          : mem_rdata_i;
   // Byte 0 is the left half of the word
   assign byte_val = bsel ? mem_rdata_i[7:0] : mem_rdata_i[15:8];
   assign opnd     = {8'h00, byte_val};
   // Unsigned full-word compare; software clears A 8-15 for a byte compare
   assign cmp_lt   = (regs.acc < opnd);
   assign cmp_gt   = (regs.acc > opnd);

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   // Memory request stays up until the ack; the ack cycle consumes data
   always_comb begin
      logic [15:0] ba;
      ba            = 16'h0000;
      next_state    = state;
      next_regs     = regs;
      next_instr    = instr;
      next_bsel     = bsel;
      next_mem_rd   = mem_rd;
      next_mem_addr = mem_addr;
      next_done     = 1'b0;
      next_cycles   = cycles;
      next_inhibit  = inhibit;
      next_unsup    = 1'b0;
      unique case (state)
         BIE_ST_IDLE: begin
            if (ld_i) begin
               // A register load wins over an instruction offered with it
               next_regs = ld_regs_i;
            end else if (instr_valid_i) begin
               // Interrupts may be taken again once the target is in
               next_inhibit = 1'b0;
               if (cls == `BIE_CLS_IMM) begin
                  // Whole operation in the taking cycle, no fetch
                  next_done   = 1'b1;
                  next_cycles = `BIE_CYC_IMM;
                  next_regs.pc = regs.pc + 16'h0001;
                  unique case (op)
                     `BIE_IMM_ADD_X: begin
                        // Operand is zero-extended, so carries ripple into X 8-15
                        next_regs.idx = x_sum;
                        if (add_ovf) begin
                           next_regs.overflow_indicator = 1'b1;
                        end
                     end
                     `BIE_IMM_SUB_X: begin
                        // Two's complement of the operand is added, not subtracted
                        next_regs.idx = x_dif;
                        if (sub_ovf) begin
                           next_regs.overflow_indicator = 1'b1;
                        end
                     end
                     `BIE_IMM_LD_XP: begin
                        next_regs.idx = dval;
                     end
                     `BIE_IMM_LD_XN: begin
                        next_regs.idx = neg_d;
                     end
                     `BIE_IMM_LD_AP: begin
                        next_regs.acc = dval;
                     end
                     `BIE_IMM_LD_AN: begin
                        next_regs.acc = neg_d;
                     end
                     default: begin
                        // Compare immediates live elsewhere
                        next_done    = 1'b0;
                        next_regs.pc = regs.pc;
                        next_unsup   = 1'b1;
                     end
                  endcase
               end else if (cls == `BIE_CLS_XOR || cls == `BIE_CLS_CMP) begin
                  // Latch the word and raise the first read on the same edge
                  next_instr  = instr_i;
                  next_mem_rd = 1'b1;
                  next_bsel   = 1'b0;
                  next_state  = instr_i[`BIE_IND_BIT] ? BIE_ST_PTR
                                                       : BIE_ST_OPND;
                  unique case (op)
                     // Direct byte address: word is ba/2, bit 0 picks the half
                     `BIE_M_SP: begin
                        ba            = dval;
                        next_bsel     = ba[0];
                        next_mem_addr = {1'b0, ba[15:1]};
                     end
                     `BIE_M_IDX: begin
                        ba            = dval + regs.idx;
                        next_bsel     = ba[0];
                        next_mem_addr = {1'b0, ba[15:1]};
                     end
                     // Byte half comes from the opcode, not from an address bit
                     `BIE_M_PF0, `BIE_M_PF1: begin
                        next_mem_addr = regs.pc + 16'h0001 + dval;
                        next_bsel     = instr_i[10];
                     end
                     `BIE_M_IPF: begin
                        next_mem_addr = regs.pc + 16'h0001 + dval;
                     end
                     // Backward pointer has no plus one, unlike the forward forms
                     `BIE_M_IPB: begin
                        next_mem_addr = regs.pc - dval;
                     end
                     `BIE_M_ISP, `BIE_M_ISPX: begin
                        // Scratchpad pointer, plain or indexed
                        next_mem_addr = dval;
                     end
                  endcase
               end else begin
                  next_unsup = 1'b1;
               end
            end
         end
         BIE_ST_PTR: begin
            if (mem_ack_i) begin
               // Second read fetches the byte the pointer names
               // Request stays high across the pointer ack; only the address moves
               next_mem_addr = {1'b0, ptr_ba[15:1]};
               next_bsel     = ptr_ba[0];
               next_state    = BIE_ST_OPND;
            end
         end
         BIE_ST_OPND: begin
            if (mem_ack_i) begin
               next_mem_rd  = 1'b0;
               next_state   = BIE_ST_IDLE;
               next_done    = 1'b1;
               next_cycles  = lind ? `BIE_CYC_IND : `BIE_CYC_BYTE;
               if (lxor) begin
                  // Upper byte of the operand is zero, so A 8-15 holds
                  next_regs.acc = regs.acc ^ opnd;
                  next_regs.pc  = regs.pc + 16'h0001;
               end else if (cmp_lt) begin
                  next_regs.pc  = regs.pc + `BIE_STEP_LT;
               end else if (cmp_gt) begin
                  next_regs.pc  = regs.pc + `BIE_STEP_GT;
                  next_inhibit  = 1'b1;
               end else begin
                  next_regs.pc  = regs.pc + `BIE_STEP_EQ;
                  next_inhibit  = 1'b1;
               end
            end
         end
         default: begin
            // Unused state code: back to idle with the request dropped
            next_state  = BIE_ST_IDLE;
            next_mem_rd = 1'b0;
         end
      endcase
      // Ready mirrors idle, so nothing is taken while a fetch is open
      next_ready = (next_state == BIE_ST_IDLE);
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   // Only constants load under reset; all outputs leave flops
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         state    <= BIE_ST_IDLE;
         regs     <= '0;
         instr    <= `BIE_WORD_RST;
         bsel     <= 1'b0;
         ready    <= 1'b1;
         mem_rd   <= 1'b0;
         mem_addr <= `BIE_WORD_RST;
         done     <= 1'b0;
         cycles   <= 2'h0;
         inhibit  <= 1'b0;
         unsup    <= 1'b0;
      end else begin
         state    <= next_state;
         regs     <= next_regs;
         instr    <= next_instr;
         bsel     <= next_bsel;
         ready    <= next_ready;
         mem_rd   <= next_mem_rd;
         mem_addr <= next_mem_addr;
         done     <= next_done;
         cycles   <= next_cycles;
         inhibit  <= next_inhibit;
         unsup    <= next_unsup;
      end
   end

   // Outputs straight from the flops
   assign ready_o        = ready;
   assign mem_rd_o       = mem_rd;
   assign mem_addr_o     = mem_addr;
   assign regs_o         = regs;
   assign done_o         = done;
   assign cycles_o       = cycles;
   assign intr_inhibit_o = inhibit;
   assign unsupported_o  = unsup;

endmodule : bie_core
`default_nettype wire

/* test/bie_mem_model.sv */
// Main memory model that answers the block's word reads
`default_nettype none
module bie_mem_model (
   input  wire logic        clk_i,
   input  wire logic        slow_i,
   input  wire logic        rd_i,
   input  wire logic [15:0] addr_i,
   output logic             ack_o,
   output logic [15:0]      rdata_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // No write port at all, so a byte op can never alter memory
   logic [15:0] mem [0:1023];
   logic [1:0]  wait_q = 2'h0;
   logic        ack_q = 1'b0;
   logic [15:0] rdata_q = 16'h0000;
   assign ack_o = ack_q;
   assign rdata_o = rdata_q;
   // One-cycle ack after an optional stall; data flips when not valid so stale words show
   always @(posedge clk_i) begin
      if (rd_i && !ack_q && wait_q >= (slow_i ? 2'h3 : 2'h0)) begin
         ack_q <= 1'b1;
         rdata_q <= mem[addr_i[9:0]];
         wait_q <= 2'h0;
      end else begin
         ack_q <= 1'b0;
         rdata_q <= ~rdata_q;
         wait_q <= (rd_i && !ack_q) ? wait_q + 2'h1 : 2'h0;
      end
   end
endmodule : bie_mem_model
`default_nettype wire

/* test/bie_core_monitor.sv */
// Checker bound to the byte and immediate execute core
`include "bie_cfg.svh"
`default_nettype none
module bie_core_monitor (
   input wire logic               clk_i,
   input wire logic               rstn_i,
   input wire logic               ld_i,
   input wire logic               instr_valid_i,
   input wire logic [15:0]        instr_i,
   input wire logic               ready_o,
   input wire logic               mem_rd_o,
   input wire logic               mem_ack_i,
   input wire logic [15:0]        mem_addr_o,
   input wire bie_pkg::bie_regs_s regs_o,
   input wire logic               done_o,
   input wire logic [1:0]         cycles_o,
   input wire logic               intr_inhibit_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import bie_pkg::*;
   logic        tk;
   logic        imm_tk;
   logic [2:0]  op;
   logic [15:0] iq;
   logic [15:0] aq;
   logic [15:0] pq;
   assign tk = ready_o && instr_valid_i && !ld_i;
   assign imm_tk = tk && instr_i[15:11] == `BIE_CLS_IMM;
   assign op = instr_i[10:8];
   // Snapshot at take, so completion can be judged however long memory stalls
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         iq <= 16'h0000;
         aq <= 16'h0000;
         pq <= 16'h0000;
      end else if (tk) begin
         iq <= instr_i;
         aq <= regs_o.acc;
         pq <= regs_o.pc;
      end
   end
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   AST_IMM_CYCLE: assert property (
      imm_tk && op[2:1] != 2'h0 |=> done_o && cycles_o == `BIE_CYC_IMM && !mem_rd_o
      && regs_o.pc == $past(regs_o.pc) + 16'h0001) else $error("immediate not done in one cycle");
   AST_LD_ACC_POS: assert property (
      imm_tk && op == `BIE_IMM_LD_AP |=> regs_o.acc == {8'h00, $past(instr_i[7:0])})
      else $error("load acc positive wrong");
   AST_LD_ACC_NEG: assert property (
      imm_tk && op == `BIE_IMM_LD_AN |=> regs_o.acc == 16'h0000 - {8'h00, $past(instr_i[7:0])})
      else $error("load acc negative wrong");
   AST_LD_IDX_NEG: assert property (
      imm_tk && op == `BIE_IMM_LD_XN |=> regs_o.idx == 16'h0000 - {8'h00, $past(instr_i[7:0])})
      else $error("load index negative wrong");
   AST_LD_IDX_POS: assert property (
      imm_tk && op == `BIE_IMM_LD_XP |=> regs_o.idx == {8'h00, $past(instr_i[7:0])})
      else $error("load index positive wrong");
   AST_SUB_IDX: assert property (
      imm_tk && op == `BIE_IMM_SUB_X |=>
      regs_o.idx == $past(regs_o.idx) - {8'h00, $past(instr_i[7:0])}) else $error("sub wrong");
   AST_ADDR_HOLD: assert property (
      mem_rd_o && !mem_ack_i |=> mem_rd_o && $stable(mem_addr_o))
      else $error("read request dropped or address moved before ack");
   AST_ADD_IDX: assert property (
      imm_tk && op == `BIE_IMM_ADD_X |=>
      regs_o.idx == $past(regs_o.idx) + {8'h00, $past(instr_i[7:0])}) else $error("add wrong");
   AST_OV_HOLD: assert property (
      regs_o.overflow_indicator && !(ready_o && ld_i) |=> regs_o.overflow_indicator)
      else $error("overflow indicator cleared");
   AST_XOR_HIGH: assert property (
      done_o && iq[15:11] == `BIE_CLS_XOR |-> regs_o.acc[15:8] == aq[15:8]
      && regs_o.pc == pq + 16'h0001) else $error("byte xor touched upper byte or pc");
   AST_CMP_KEEP: assert property (
      done_o && iq[15:11] == `BIE_CLS_CMP |-> regs_o.acc == aq
      && regs_o.pc - pq inside {16'h0001, 16'h0002, 16'h0003}) else $error("compare wrong");
   AST_INHIBIT: assert property (
      done_o && iq[15:11] == `BIE_CLS_CMP |-> intr_inhibit_o == (regs_o.pc != pq + 16'h0001))
      else $error("inhibit does not follow skip");
   AST_BYTE_CYCLES: assert property (
      done_o && (iq[15:11] == `BIE_CLS_XOR || iq[15:11] == `BIE_CLS_CMP) |->
      cycles_o == (iq[8] ? `BIE_CYC_IND : `BIE_CYC_BYTE)) else $error("byte cycle count wrong");
   cover property (imm_tk);
   cover property (done_o && intr_inhibit_o);
   cover property (done_o && cycles_o == `BIE_CYC_IND);
   cover property (mem_rd_o && mem_ack_i);
endmodule : bie_core_monitor
bind bie_core bie_core_monitor u_mon (.clk_i(clk_i), .rstn_i(rstn_i), .ld_i(ld_i),
   .instr_valid_i(instr_valid_i), .instr_i(instr_i), .ready_o(ready_o), .mem_rd_o(mem_rd_o),
   .mem_ack_i(mem_ack_i), .mem_addr_o(mem_addr_o),
   .regs_o(regs_o), .done_o(done_o), .cycles_o(cycles_o), .intr_inhibit_o(intr_inhibit_o));
`default_nettype wire

/* test/test_byte_and_immediate_execute.sv */
// Self-checking bench for the byte and immediate execute core
`default_nettype none
module test_byte_and_immediate_execute;
   timeunit 1ns;
   timeprecision 1ps;
   import bie_pkg::*;
   logic        clk_i = 1'b0;
   logic        rstn_i = 1'b0;
   logic        ld_i = 1'b0;
   logic        instr_valid_i = 1'b0;
   logic        slow = 1'b0;
   logic        unsup_seen;
   logic [15:0] instr_i = 16'h0000;
   logic [15:0] mem_addr_o, mem_rdata_i, pc_e;
   logic        mem_ack_i, ready_o, mem_rd_o, done_o, intr_inhibit_o, unsupported_o;
   logic [1:0]  cycles_o;
   bie_regs_s   ld_regs_i = '0;
   bie_regs_s   regs_o;
   int          n_errors = 0;
   int          num_checks = 0;
   int          cyc = 0;
   always #5 clk_i = ~clk_i;
   bie_core uut (.clk_i(clk_i), .rstn_i(rstn_i), .ld_i(ld_i), .ld_regs_i(ld_regs_i),
      .instr_valid_i(instr_valid_i), .instr_i(instr_i), .mem_ack_i(mem_ack_i),
      .mem_rdata_i(mem_rdata_i), .ready_o(ready_o), .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o),
      .regs_o(regs_o), .done_o(done_o), .cycles_o(cycles_o), .intr_inhibit_o(intr_inhibit_o),
      .unsupported_o(unsupported_o));
   bie_mem_model mem_model (.clk_i(clk_i), .slow_i(slow), .rd_i(mem_rd_o),
      .addr_i(mem_addr_o), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));
   // ----------------------------------------
   // Access tasks
   // ----------------------------------------
   task automatic tally_and_finish;
      if (n_errors == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic load(input logic [15:0] a, input logic [15:0] x, input logic [15:0] p,
                       input logic ov);
      @(posedge clk_i);
      ld_i <= 1'b1;
      ld_regs_i <= '{acc: a, idx: x, pc: p, overflow_indicator: ov};
      @(posedge clk_i);
      ld_i <= 1'b0;
      pc_e = p;
   endtask : load
   // Offer for one edge, then wait for done or refusal on falling edges
   task automatic exec(input logic [15:0] w);
      int n;
      @(posedge clk_i);
      instr_valid_i <= 1'b1;
      instr_i <= w;
      @(posedge clk_i);
      instr_valid_i <= 1'b0;
      for (n = 0; n < 40; n++) begin
         @(negedge clk_i);
         if (done_o === 1'b1 || unsupported_o === 1'b1) break;
      end
      unsup_seen = unsupported_o;
   endtask : exec
   task automatic imm(input logic [15:0] w, input logic x, input logic [15:0] e,
                      input logic ov);
      exec(w);
      pc_e = pc_e + 16'h0001;
      chk("value", x ? regs_o.idx : regs_o.acc, e);
      chk("overflow", 16'(regs_o.overflow_indicator), 16'(ov));
      chk("cycles", 16'(cycles_o), 16'h0001);
      chk("pc", regs_o.pc, pc_e);
   endtask : imm
   // Memory stall alternates between calls so both answer speeds are seen
   task automatic byte_op(input logic [15:0] w, input logic [15:0] a, input logic [15:0] e,
                          input logic [1:0] step, input logic [1:0] cy, input logic inh);
      slow = ~slow;
      load(a, 16'h0005, 16'h0100, 1'b0);
      exec(w);
      chk("acc", regs_o.acc, e);
      chk("pc", regs_o.pc, 16'h0100 + 16'(step));
      chk("cycles", 16'(cycles_o), 16'(cy));
      chk("inhibit", 16'(intr_inhibit_o), 16'(inh));
   endtask : byte_op
   always @(posedge clk_i) begin
      cyc++;
      if (cyc > 3000) begin
         n_errors++;
         tally_and_finish;
      end
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      mem_model.mem[4] = 16'h2200;
      mem_model.mem[5] = 16'h0101;
      mem_model.mem[6] = 16'h0010;
      mem_model.mem[8] = 16'h5AC3;
      mem_model.mem[10] = 16'h00F0;
      mem_model.mem[128] = 16'h77C4;
      mem_model.mem[253] = 16'h0200;
      mem_model.mem[256] = 16'h3C00;
      mem_model.mem[258] = 16'h0011;
      mem_model.mem[259] = 16'h9911;
      mem_model.mem[261] = 16'hAA60;
      repeat (16) @(posedge clk_i);
      rstn_i <= 1'b1;
      load(16'h1234, 16'h7FF0, 16'h0100, 1'b0);
      imm(16'hC605, 1'b0, 16'h0005, 1'b0);
      imm(16'hC705, 1'b0, 16'hFFFB, 1'b0);
      imm(16'hC700, 1'b0, 16'h0000, 1'b0);
      imm(16'hC4AB, 1'b1, 16'h00AB, 1'b0);
      imm(16'hC501, 1'b1, 16'hFFFF, 1'b0);
      imm(16'hC2FF, 1'b1, 16'h00FE, 1'b0);
      imm(16'hC3FF, 1'b1, 16'hFFFF, 1'b0);
      load(16'h0005, 16'h7FF0, 16'h0200, 1'b0);
      imm(16'hC220, 1'b1, 16'h8010, 1'b1);
      imm(16'hC301, 1'b1, 16'h800F, 1'b1);
      load(16'h0005, 16'h8000, 16'h0200, 1'b0);
      imm(16'hC301, 1'b1, 16'h7FFF, 1'b1);
      exec(16'hC005);
      chk("unsupported", 16'(unsup_seen), 16'h0001);
      chk("pc", regs_o.pc, pc_e);
      exec(16'h0000);
      chk("unsupported", 16'(unsup_seen), 16'h0001);
      byte_op(16'hA810, 16'h1234, 16'h126E, 2'h1, 2'h2, 1'b0);
      byte_op(16'hAA02, 16'h1234, 16'h12AD, 2'h1, 2'h2, 1'b0);
      byte_op(16'hA905, 16'h1234, 16'h12F0, 2'h1, 2'h3, 1'b0);
      byte_op(16'hAF03, 16'h1234, 16'h1208, 2'h1, 2'h3, 1'b0);
      byte_op(16'hAB01, 16'h1234, 16'h12F7, 2'h1, 2'h3, 1'b0);
      byte_op(16'hAD06, 16'h1234, 16'h12C4, 2'h1, 2'h3, 1'b0);
      byte_op(16'hD604, 16'h0070, 16'h0070, 2'h2, 2'h2, 1'b1);
      byte_op(16'hD604, 16'h0050, 16'h0050, 2'h1, 2'h2, 1'b0);
      byte_op(16'hD604, 16'h0060, 16'h0060, 2'h3, 2'h2, 1'b1);
      byte_op(16'hD604, 16'h0150, 16'h0150, 2'h2, 2'h2, 1'b1);
      byte_op(16'hD105, 16'h00C4, 16'h00C4, 2'h3, 2'h3, 1'b1);
      byte_op(16'hD403, 16'h0022, 16'h0022, 2'h3, 2'h2, 1'b1);
      tally_and_finish;
   end
endmodule : test_byte_and_immediate_execute
`default_nettype wire
